// [rtl/dsde_top.sv]
// Decode and execute of the doubleword store group.
// Assumes one instruction per i_valid pulse, register reads combinational,
// and that snoop writes from other agents arrive on the same clock.
// Contract
// [RQ1] Conditional indexed store: opcode 31, extended 214, bit 31 set.
// [RQ2] Matching reservation: write source doubleword, then clear reservation.
// [RQ3] Mismatching reservation: clear it; this design does not write.
// [RQ4] No reservation: conditional store completes without memory write.
// [RQ5] Condition field 0 bits 0-2 are 001 if stored, else 000.
// [RQ6] Summary overflow copied into condition field 0 bit 3.
// [RQ7] Conditional store address not multiple of eight raises alignment.
// [RQ8] Reservation cleared by new reserve, any store-conditional, others; code keeps it on a misaligned or 32-bit store-conditional.
// [RQ9] Conditional store address is base plus index, or index if base zero.
// [RQ10] Update displacement store: opcode 62, bits 30-31 equal 01.
// [RQ11] Displacement is sign-extended field times four, plus base if nonzero.
// [RQ12] Update displacement store with zero base is an invalid form.
// [RQ13] Update displacement store writes address back into base register.
// [RQ14] Indexed update store: opcode 31, extended 181, bit 31 clear.
// [RQ15] Indexed update store: base plus index, updates base; zero invalid.
// [RQ16] Plain indexed store: opcode 31, extended 149, bit 31 clear.
// [RQ17] Plain indexed address is base plus index, or index if base zero.
// [RQ18] On a 32-bit implementation fixed-point doubleword stores are illegal.
// [RQ19] Float store: opcode 54, float source, base, signed displacement.
// [RQ20] Float store writes whole float register, leaves condition unchanged.
`timescale 1ns/100ps
`default_nettype none
module dsde_top (
   input  wire logic                 i_clk,
   input  wire logic                 i_reset_n,
   input  wire logic                 i_valid,
   input  wire logic [31:0]          i_insn,
   input  wire logic                 i_mode64,
   input  wire logic [63:0]          i_source_reg,
   input  wire logic [63:0]          i_base_reg,
   input  wire logic [63:0]          i_index_reg,
   input  wire logic [63:0]          i_float_source_reg,
   input  wire logic                 i_summary_ovf,
   input  wire logic                 i_resv_set,
   input  wire logic [63:0]          i_resv_addr,
   input  wire logic                 i_snoop_we,
   input  wire logic [63:0]          i_snoop_addr,
   output logic [4:0]                o_source_idx,
   output logic [4:0]                o_base_idx,
   output logic [4:0]                o_index_idx,
   output dsde_pkg::dsde_mem_t       o_mem,
   output dsde_pkg::dsde_wb_t        o_wb,
   output dsde_pkg::dsde_exc_t       o_exc,
   output logic                      o_done,
   output logic                      o_resv_held
);
   dsde_pkg::dsde_op_t op;
   logic [4:0]  ra;
   logic [63:0] ea;
   logic [63:0] disp_ds;
   logic [63:0] disp_d;
   logic        fixed_op;
   logic        base_zero;
   logic        misalign;
   logic        resv_held;
   logic [63:0] resv_addr;
   logic        stcx_go;
   logic        stcx_hit;
   logic        bad_form;

   // Decode of the instruction word; bit 0 of the doc is our bit 31
   function automatic dsde_pkg::dsde_op_t decode(input logic [31:0] w);
      logic [5:0] po;
      logic [9:0] xo;
      po = w[31:26];
      xo = w[10:1];
      decode = dsde_pkg::DSDE_NONE;
      if (po == dsde_pkg::OP_X && xo == dsde_pkg::XO_STCX && w[0])
         decode = dsde_pkg::DSDE_STCX; // RQ1
      else if (po == dsde_pkg::OP_DS && w[1:0] == dsde_pkg::DS_UPDATE)
         decode = dsde_pkg::DSDE_STU; // RQ10
      else if (po == dsde_pkg::OP_X && xo == dsde_pkg::XO_STUX && !w[0])
         decode = dsde_pkg::DSDE_STUX; // RQ14
      else if (po == dsde_pkg::OP_X && xo == dsde_pkg::XO_STX && !w[0])
         decode = dsde_pkg::DSDE_STX; // RQ16
      else if (po == dsde_pkg::OP_FD)
         decode = dsde_pkg::DSDE_STFD; // RQ19
   endfunction

   always_comb begin
      op           = i_valid ? decode(i_insn) : dsde_pkg::DSDE_NONE;
      ra           = i_insn[20:16];
      o_source_idx = i_insn[25:21];
      o_base_idx   = ra;
      o_index_idx  = i_insn[15:11];
      base_zero    = (ra == dsde_pkg::REG_ZERO);
   end

   // Displacements: scaled field and plain signed field
   always_comb begin
      disp_ds = {{50{i_insn[15]}}, i_insn[15:2]} <<< dsde_pkg::DS_SHIFT; // RQ11
      disp_d  = {{48{i_insn[15]}}, i_insn[15:0]}; // RQ20
   end

   // Effective address, with zero base taken as no base except in the indexed update store
   always_comb begin
      unique case (op)
         dsde_pkg::DSDE_STU:
            ea = base_zero ? disp_ds : i_base_reg + disp_ds; // RQ11
         dsde_pkg::DSDE_STFD:
            ea = base_zero ? disp_d : i_base_reg + disp_d; // RQ20
         dsde_pkg::DSDE_STUX:
            ea = i_base_reg + i_index_reg; // RQ15
         dsde_pkg::DSDE_STCX,
         dsde_pkg::DSDE_STX:
            ea = base_zero ? i_index_reg
                           : i_base_reg + i_index_reg; // RQ9 RQ17
         default:
            ea = 64'h0;
      endcase
   end

   always_comb begin
      fixed_op = (op == dsde_pkg::DSDE_STCX) || (op == dsde_pkg::DSDE_STU) ||
                 (op == dsde_pkg::DSDE_STUX) || (op == dsde_pkg::DSDE_STX);
      misalign = (op == dsde_pkg::DSDE_STCX) &&
                 ((ea[2:0] & dsde_pkg::ALIGN_MSK) != 3'h0); // RQ7
      bad_form = ((op == dsde_pkg::DSDE_STU) ||
                  (op == dsde_pkg::DSDE_STUX)) && base_zero; // RQ12 RQ15
      stcx_go  = (op == dsde_pkg::DSDE_STCX) && i_mode64 && !misalign;
      stcx_hit = stcx_go && resv_held && (ea == resv_addr); // RQ2 RQ3 RQ4
   end

   dsde_resv u_resv (
      .i_clk        (i_clk),
      .i_reset_n    (i_reset_n),
      .i_set        (i_resv_set),
      .i_set_addr   (i_resv_addr),
      .i_clear      (stcx_go), // RQ8
      .i_snoop_we   (i_snoop_we),
      .i_snoop_addr (i_snoop_addr),
      .o_held       (resv_held),
      .o_addr       (resv_addr)
   );

   // Memory write
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_mem <= '0;
      end else begin
         o_mem.valid <= 1'b0;
         o_mem.addr  <= ea;
         o_mem.data  <= i_source_reg;
         if (op == dsde_pkg::DSDE_STCX)
            o_mem.valid <= stcx_hit; // RQ2 RQ3 RQ4
         else if (op == dsde_pkg::DSDE_STFD) begin
            o_mem.valid <= 1'b1;
            o_mem.data  <= i_float_source_reg; // RQ20
         end else if (fixed_op)
            o_mem.valid <= i_mode64 && !bad_form; // RQ18
      end
   end

   // Base update and condition field 0
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_wb <= '0;
      end else begin
         o_wb.gpr_we   <= ((op == dsde_pkg::DSDE_STU) ||
                           (op == dsde_pkg::DSDE_STUX)) &&
                          i_mode64 && !base_zero; // RQ13 RQ15
         o_wb.gpr_idx  <= ra;
         o_wb.gpr_data <= ea;
         o_wb.cr0_we   <= stcx_go; // RQ5 RQ20
         o_wb.cr0      <= {stcx_hit ? dsde_pkg::CR_STORED
                                    : dsde_pkg::CR_FAILED, // RQ5
                           i_summary_ovf}; // RQ6
      end
   end

   // Exceptions and completion
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_exc       <= '0;
         o_done      <= 1'b0;
         o_resv_held <= 1'b0;
      end else begin
         o_exc.illegal      <= fixed_op && !i_mode64; // RQ18
         o_exc.invalid_form <= bad_form && i_mode64;
         o_exc.align        <= misalign && i_mode64; // RQ7
         o_done             <= (op != dsde_pkg::DSDE_NONE);
         o_resv_held        <= resv_held;
      end
   end

   stcx_hit_store_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      stcx_hit |=> o_mem.valid && o_wb.cr0[3:1] == 3'h1) // RQ2
      else $error("matching conditional store did not write");
   stcx_miss_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      stcx_go && !stcx_hit |=> !o_mem.valid && o_wb.cr0[3:1] == 3'h0) // RQ4
      else $error("failed conditional store wrote memory");
   resv_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      stcx_go && !i_resv_set |=> !resv_held) // RQ8
      else $error("reservation survived conditional store");
   cr0_ovf_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      stcx_go |=> o_wb.cr0_we && o_wb.cr0[0] == $past(i_summary_ovf)) // RQ6
      else $error("summary overflow not copied");
   align_trap_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      op == dsde_pkg::DSDE_STCX && i_mode64 && ea[2:0] != 3'h0
      |=> o_exc.align && !o_mem.valid) // RQ7
      else $error("misaligned conditional store not trapped");
   base_update_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      op == dsde_pkg::DSDE_STU && i_mode64 && !base_zero
      |=> o_wb.gpr_we && o_wb.gpr_data == $past(i_base_reg) + $past(disp_ds))
      // RQ13
      else $error("base not updated with address");
   illegal32_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      fixed_op && !i_mode64 |=> o_exc.illegal && !o_mem.valid) // RQ18
      else $error("doubleword store on 32-bit not illegal");
   float_store_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      op == dsde_pkg::DSDE_STFD |=> o_mem.valid && !o_wb.cr0_we &&
      o_mem.data == $past(i_float_source_reg)) // RQ20
      else $error("float store wrong");
   invalid_form_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      op == dsde_pkg::DSDE_STUX && base_zero && i_mode64
      |=> o_exc.invalid_form && !o_wb.gpr_we) // RQ15
      else $error("zero base indexed update not invalid");
   indexed_ea_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      op == dsde_pkg::DSDE_STX && base_zero && i_mode64
      |=> o_mem.valid && o_mem.addr == $past(i_index_reg)) // RQ17
      else $error("zero base indexed address wrong");

   // Completion and silence on unrecognised words
   done_pulse_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      op != dsde_pkg::DSDE_NONE |=> o_done) // RQ1
      else $error("recognised instruction did not complete");
   unknown_quiet_a: assert property (@(posedge i_clk)
      disable iff (!i_reset_n)
      op == dsde_pkg::DSDE_NONE
      |=> !o_done && !o_mem.valid && !o_wb.gpr_we && !o_wb.cr0_we) // RQ1
      else $error("unrecognised word had an effect");

   // Update forms
   stdu_invalid_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      op == dsde_pkg::DSDE_STU && base_zero && i_mode64
      |=> o_exc.invalid_form && !o_mem.valid && !o_wb.gpr_we) // RQ12
      else $error("zero base update store not invalid");
   stux_update_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      op == dsde_pkg::DSDE_STUX && i_mode64 && !base_zero
      |=> o_wb.gpr_we &&
          o_wb.gpr_data == $past(i_base_reg) + $past(i_index_reg)) // RQ15
      else $error("indexed update base wrong");
   wb_idle_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !fixed_op |=> !o_wb.gpr_we && !o_exc.illegal) // RQ18
      else $error("base update or trap without fixed store");

   // Float store
   stfd_mode32_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      op == dsde_pkg::DSDE_STFD && !i_mode64
      |=> o_mem.valid && !o_exc.illegal) // RQ18 RQ20
      else $error("float store blocked in 32-bit mode");
   stfd_addr_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      op == dsde_pkg::DSDE_STFD && base_zero
      |=> o_mem.addr == $past(disp_d)) // RQ20
      else $error("zero base float address wrong");

   // Conditional store and reservation
   stcx_data_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      stcx_hit |=> o_mem.addr == $past(resv_addr) &&
                   o_mem.data == $past(i_source_reg)) // RQ2
      else $error("conditional store address or data wrong");
   stcx_mode32_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      op == dsde_pkg::DSDE_STCX && !i_mode64
      |=> o_exc.illegal && !o_wb.cr0_we) // RQ18
      else $error("conditional store on 32-bit not illegal");
   resv_kept_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      misalign && i_mode64 && !i_resv_set && !i_snoop_we
      |=> resv_held == $past(resv_held)) // RQ7
      else $error("misaligned store changed reservation");
   snoop_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_snoop_we && i_snoop_addr == resv_addr && !i_resv_set
      |=> !resv_held) // RQ8
      else $error("snoop write kept reservation");
   resv_set_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_resv_set |=> resv_held && resv_addr == $past(i_resv_addr)) // RQ8
      else $error("reservation not established");
   held_mirror_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      resv_held |=> o_resv_held) // RQ8
      else $error("reservation state not shown");
endmodule
`default_nettype wire

// [rtl/dsde_pkg.sv]
// Package for the doubleword store decode and execute block.
// Assumes a 64-bit register file outside that answers reads combinationally.
package dsde_pkg;
   localparam logic [5:0] OP_X      = 6'h1F;  // 31
   localparam logic [5:0] OP_DS     = 6'h3E;  // 62
   localparam logic [5:0] OP_FD     = 6'h36;  // 54
   localparam logic [9:0] XO_STCX   = 10'h0D6; // 214
   localparam logic [9:0] XO_STUX   = 10'h0B5; // 181
   localparam logic [9:0] XO_STX    = 10'h095; // 149
   localparam logic [1:0] DS_UPDATE = 2'h1;
   localparam logic [2:0] CR_STORED = 3'h1;
   localparam logic [2:0] CR_FAILED = 3'h0;
   localparam logic [4:0] REG_ZERO  = 5'h00;
   localparam logic [2:0] ALIGN_MSK = 3'h7;
   localparam int         DS_SHIFT  = 2;

   typedef enum logic [5:0] {
      DSDE_NONE = 6'h01,
      DSDE_STCX = 6'h02,
      DSDE_STU  = 6'h04,
      DSDE_STUX = 6'h08,
      DSDE_STX  = 6'h10,
      DSDE_STFD = 6'h20
   } dsde_op_t;

   // Memory write request
   typedef struct packed {
      logic        valid;
      logic [63:0] addr;
      logic [63:0] data;
   } dsde_mem_t;

   // Register writeback: base update and condition field 0
   typedef struct packed {
      logic        gpr_we;
      logic [4:0]  gpr_idx;
      logic [63:0] gpr_data;
      logic        cr0_we;
      logic [3:0]  cr0;
   } dsde_wb_t;

   // Exception signals
   typedef struct packed {
      logic illegal;
      logic invalid_form;
      logic align;
   } dsde_exc_t;
endpackage

// [rtl/dsde_resv.sv]
// Reservation holder for the conditional doubleword store.
// Assumes the load-and-reserve unit and snoop logic share i_clk.
`timescale 1ns/100ps
`default_nettype none
module dsde_resv (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_set,
   input  wire logic [63:0] i_set_addr,
   input  wire logic        i_clear,
   input  wire logic        i_snoop_we,
   input  wire logic [63:0] i_snoop_addr,
   output logic             o_held,
   output logic [63:0]      o_addr
);
   // A new reservation wins over any clear in the same cycle
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_held <= 1'b0;
         o_addr <= 64'h0;
      end else if (i_set) begin
         o_held <= 1'b1; // RQ8
         o_addr <= i_set_addr;
      end else if (i_clear ||
                   (i_snoop_we && i_snoop_addr == o_addr)) begin
         o_held <= 1'b0; // RQ8
      end
   end
endmodule
`default_nettype wire

// [tb/dsde_regs.sv]
// Register file model for the store decoder's read ports.
// Assumes the decoder's index outputs drive its reads in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module dsde_regs (
   input  wire logic [4:0] i_source_idx,
   input  wire logic [4:0] i_base_idx,
   input  wire logic [4:0] i_index_idx,
   input  wire logic [2:0] i_skew,
   output logic [63:0]     o_source,
   output logic [63:0]     o_base,
   output logic [63:0]     o_index,
   output logic [63:0]     o_float
);
   assign o_source = {32'hA5A50000, 27'h0, i_source_idx};
   assign o_float  = ~o_source;
   assign o_base   = {51'h0, i_base_idx, 8'h00};
   // Skew lets a scenario misalign an indexed address
   assign o_index  = {55'h0, i_index_idx, 4'h0} + {61'h0, i_skew};
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the doubleword store decoder.
// Assumes the register model answers reads in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic                i_clk, i_reset_n, i_valid, i_mode64, i_so;
   logic                i_resv_set, i_snoop_we;
   logic [31:0]         i_insn;
   logic [63:0]         i_resv_addr, i_snoop_addr, s_v, b_v, x_v, f_v;
   logic [2:0]          skew;
   logic [4:0]          s_idx, b_idx, x_idx;
   dsde_pkg::dsde_mem_t o_mem;
   dsde_pkg::dsde_wb_t  o_wb;
   dsde_pkg::dsde_exc_t o_exc;
   logic                o_done, o_resv_held;
   int                  fail_count, tests_run;
   dsde_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_valid(i_valid),
      .i_insn(i_insn), .i_mode64(i_mode64), .i_source_reg(s_v),
      .i_base_reg(b_v), .i_index_reg(x_v), .i_float_source_reg(f_v),
      .i_summary_ovf(i_so), .i_resv_set(i_resv_set),
      .i_resv_addr(i_resv_addr), .i_snoop_we(i_snoop_we),
      .i_snoop_addr(i_snoop_addr), .o_source_idx(s_idx),
      .o_base_idx(b_idx), .o_index_idx(x_idx), .o_mem(o_mem), .o_wb(o_wb),
      .o_exc(o_exc), .o_done(o_done), .o_resv_held(o_resv_held));
   dsde_regs regs (.i_source_idx(s_idx), .i_base_idx(b_idx),
      .i_index_idx(x_idx), .i_skew(skew), .o_source(s_v), .o_base(b_v),
      .o_index(x_v), .o_float(f_v));
   function automatic logic [63:0] src(input logic [4:0] i);
      return {32'hA5A50000, 27'h0, i};
   endfunction
   function automatic logic [31:0] xf(input logic [4:0] ra,
                                      input logic [9:0] xo, input logic rc);
      return {dsde_pkg::OP_X, 5'h01, ra, 5'h04, xo, rc};
   endfunction
   task automatic chk(input string n, input logic [63:0] e,
                      input logic [63:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_mem(input logic v, input logic [63:0] a,
                          input logic [63:0] d);
      chk("mem valid", {63'h0, v}, {63'h0, o_mem.valid});
      if (v) begin
         chk("mem addr", a, o_mem.addr);
         chk("mem data", d, o_mem.data);
      end
   endtask
   task automatic run(input logic [31:0] w);
      @(posedge i_clk);
      i_valid <= 1'b1;
      i_insn <= w;
      @(posedge i_clk);
      i_valid <= 1'b0;
      #1;
   endtask
   task automatic settle(input logic held);
      repeat (2) @(posedge i_clk);
      #1;
      chk("resv held", {63'h0, held}, {63'h0, o_resv_held});
   endtask
   task automatic set_resv(input logic [63:0] a);
      @(posedge i_clk);
      i_resv_set <= 1'b1;
      i_resv_addr <= a;
      @(posedge i_clk);
      i_resv_set <= 1'b0;
      settle(1'b1);
   endtask
   task automatic t_stx;
      run(xf(5'h02, dsde_pkg::XO_STX, 1'b0));
      chk_mem(1'b1, 64'h240, src(5'h01));
      chk("base update", 64'h0, {63'h0, o_wb.gpr_we});
      chk("done", 64'h1, {63'h0, o_done});
      run(xf(5'h00, dsde_pkg::XO_STX, 1'b0));
      chk_mem(1'b1, 64'h40, src(5'h01));
   endtask
   task automatic t_upd(input logic [31:0] w, input logic [63:0] a);
      run(w);
      chk_mem(1'b1, a, src(5'h01));
      chk("wb we", 64'h1, {63'h0, o_wb.gpr_we});
      chk("wb idx", {59'h0, w[20:16]}, {59'h0, o_wb.gpr_idx});
      chk("wb data", a, o_wb.gpr_data);
      run({w[31:21], 5'h00, w[15:0]});
      chk("invalid", 64'h1, {63'h0, o_exc.invalid_form});
      chk_mem(1'b0, 64'h0, 64'h0);
   endtask
   task automatic t_stfd(input logic [4:0] ra, input logic [63:0] a);
      run({dsde_pkg::OP_FD, 5'h07, ra, 16'hFFF8});
      chk_mem(1'b1, a, ~src(5'h07));
      chk("cr0 we", 64'h0, {63'h0, o_wb.cr0_we});
   endtask
   task automatic t_stcx;
      @(posedge i_clk);
      i_so <= 1'b1;
      run(xf(5'h02, dsde_pkg::XO_STCX, 1'b0));
      chk("done", 64'h0, {63'h0, o_done});
      run(xf(5'h02, dsde_pkg::XO_STCX, 1'b1));
      chk_mem(1'b0, 64'h0, 64'h0);
      chk("cr0", 64'h1, {60'h0, o_wb.cr0});
      set_resv(64'h240);
      run(xf(5'h02, dsde_pkg::XO_STCX, 1'b1));
      chk_mem(1'b1, 64'h240, src(5'h01));
      chk("cr0", 64'h3, {60'h0, o_wb.cr0});
      chk("cr0 we", 64'h1, {63'h0, o_wb.cr0_we});
      settle(1'b0);
      i_so <= 1'b0;
      set_resv(64'h800);
      run(xf(5'h02, dsde_pkg::XO_STCX, 1'b1));
      chk_mem(1'b0, 64'h0, 64'h0);
      chk("cr0", 64'h0, {60'h0, o_wb.cr0});
      settle(1'b0);
      set_resv(64'h240);
      i_snoop_we <= 1'b1;
      i_snoop_addr <= 64'h240;
      @(posedge i_clk);
      i_snoop_we <= 1'b0;
      settle(1'b0);
      set_resv(64'h244);
      skew <= 3'h4;
      run(xf(5'h02, dsde_pkg::XO_STCX, 1'b1));
      chk("align", 64'h1, {63'h0, o_exc.align});
      chk_mem(1'b0, 64'h0, 64'h0);
      skew <= 3'h0;
      settle(1'b1);
   endtask
   task automatic t_mode32;
      @(posedge i_clk);
      i_mode64 <= 1'b0;
      run(xf(5'h02, dsde_pkg::XO_STX, 1'b0));
      chk("illegal", 64'h1, {63'h0, o_exc.illegal});
      chk_mem(1'b0, 64'h0, 64'h0);
      t_stfd(5'h03, 64'h2F8);
      run(32'h00000000);
      chk("done", 64'h0, {63'h0, o_done});
      i_mode64 <= 1'b1;
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   initial begin
      #100000;
      fail_count++;
      finish_test;
   end
   initial begin
      {fail_count, tests_run} = '0;
      {i_reset_n, i_valid, i_so, i_resv_set, i_snoop_we} = '0;
      {i_insn, i_resv_addr, i_snoop_addr, skew} = '0;
      i_mode64 = 1'b1;
      repeat (16) @(posedge i_clk);
      i_reset_n <= 1'b1;
      t_stx;
      t_upd({dsde_pkg::OP_DS, 5'h01, 5'h05, 14'h3FFF, 2'h1}, 64'h4FC);
      t_upd(xf(5'h06, dsde_pkg::XO_STUX, 1'b0), 64'h640);
      t_stfd(5'h00, 64'hFFFFFFFFFFFFFFF8);
      t_stcx;
      t_mode32;
      finish_test;
   end
endmodule
`default_nettype wire
